// *** hdl/ssse_pkg.sv ***
package ssse_pkg;

  // ----------------------------------------
  // status channel words
  // ----------------------------------------
  localparam logic [1:0] SSSE_STAT_FRAME     = 2'h3;
  localparam logic [1:0] SSSE_STAT_SATISFIED = 2'h2;
  localparam int         SSSE_FRAME_LOSS_RUN = 4;
  localparam logic [1:0] SSSE_DIP2_SEED      = 2'h0;

  // ----------------------------------------
  // data path words and fields
  // ----------------------------------------
  localparam int         SSSE_CREDIT_WORDS  = 8;
  localparam logic [3:0] SSSE_DIP4_FILL     = 4'hf;
  localparam logic [1:0] SSSE_EOPS_NONE     = 2'h0;
  localparam logic [1:0] SSSE_EOPS_ABORT    = 2'h1;
  localparam logic [1:0] SSSE_EOPS_TWO      = 2'h2;
  localparam logic [1:0] SSSE_EOPS_ONE      = 2'h3;
  localparam logic [15:0] SSSE_TRAIN_CTL    = 16'h0fff;
  localparam logic [15:0] SSSE_TRAIN_DATA   = 16'hf000;
  localparam int         SSSE_TRAIN_REPS    = 10;
  localparam int         SSSE_TRAIN_LEN     = 2 * SSSE_TRAIN_REPS + 1;

  // ----------------------------------------
  // fifo entry layout
  // ----------------------------------------
  localparam int SSSE_FE_CHAN_LSB  = 16;
  localparam int SSSE_FE_MOD_BIT   = 24;
  localparam int SSSE_FE_EOP_BIT   = 25;
  localparam int SSSE_FE_SOP_BIT   = 26;
  localparam int SSSE_FE_ABORT_BIT = 27;
  localparam int SSSE_FE_W         = 28;
  localparam int SSSE_FIFO_DEPTH   = 16;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {SSSE_RESET, SSSE_HUNT, SSSE_SYNC} ssse_state_t;
  typedef enum logic [1:0] {PH_SEARCH, PH_ENTRY, PH_DIP, PH_FRAME} ssse_phase_t;
  typedef enum logic {TX_GAP, TX_BURST} ssse_tx_t;

  function automatic logic [15:0] ssse_ctl_word(input logic       typ,
                                                input logic [1:0] eops,
                                                input logic       sop,
                                                input logic [7:0] chan);
    ssse_ctl_word = {typ, eops, sop, chan, SSSE_DIP4_FILL};
  endfunction

  function automatic logic [1:0] ssse_dip2_step(input logic [1:0] acc,
                                                input logic [1:0] w);
    ssse_dip2_step = {acc[0] ^ w[1], acc[1] ^ w[0]};
  endfunction

endpackage

// *** hdl/ssse_sampler.sv ***
`timescale 1ns/10ps
module ssse_sampler (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // status link pins
  input  wire logic       link_clk,
  input  wire logic [1:0] link_data,
  // sampled words
  output logic            word_stb,
  output logic [1:0]      word
);
  logic       clk_meta_reg;
  logic       clk_sync_reg;
  logic       clk_prev_reg;
  logic [1:0] dat_meta_reg;
  logic [1:0] dat_sync_reg;

  // ----------------------------------------
  // two-flop synchronisers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      clk_meta_reg <= 1'b0;
      clk_sync_reg <= 1'b0;
      clk_prev_reg <= 1'b0;
      dat_meta_reg <= 2'h0;
      dat_sync_reg <= 2'h0;
    end else begin
      clk_meta_reg <= link_clk;
      clk_sync_reg <= clk_meta_reg;
      clk_prev_reg <= clk_sync_reg;
      dat_meta_reg <= link_data;
      dat_sync_reg <= dat_meta_reg;
    end
  end

  // ----------------------------------------
  // word capture
  // ----------------------------------------
  // taken on the falling edge: mid-bit, far from where the far end changes it
  always_ff @(posedge clk) begin
    if (!resetn) begin
      word_stb <= 1'b0;
      word     <= 2'h0;
    end else begin
      word_stb <= clk_prev_reg & ~clk_sync_reg;
      if (clk_prev_reg & ~clk_sync_reg) begin
        word <= dat_sync_reg;
      end
    end
  end
endmodule

// *** hdl/ssse_fifo.sv ***
`timescale 1ns/10ps
module ssse_fifo #(
  parameter int W     = 28,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic         clear_low,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0]   count_reg;
  logic [AW:0]   count_next;
  logic          push;
  logic          load;

  assign push = in_valid & in_ready;
  assign load = (count_reg != '0) & (~out_valid | out_ready);

  always_comb begin
    count_next = count_reg;
    if (push && !load) begin
      count_next = count_reg + 1'b1;
    end else if (!push && load) begin
      count_next = count_reg - 1'b1;
    end
  end

  // ----------------------------------------
  // storage
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // ----------------------------------------
  // pointers, level and registered read
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn || !clear_low) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
      in_ready   <= 1'b1;
      out_valid  <= 1'b0;
      out_data   <= '0;
    end else begin
      count_reg <= count_next;
      in_ready  <= count_next < (AW + 1)'(DEPTH);
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (load) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
        out_data   <= mem[rd_ptr_reg];
        out_valid  <= 1'b1;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
    end
  end
endmodule

// *** hdl/ssse_top.sv ***
`timescale 1ns/10ps
module ssse_top
  import ssse_pkg::*;
#(
  parameter int CNT_W = 4
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             resetn,
  // configuration
  input  wire logic             source_enable,
  input  wire logic [CNT_W-1:0] sync_match_count,
  input  wire logic [CNT_W-1:0] loss_error_count,
  input  wire logic [7:0]       calendar_length,
  input  wire logic [3:0]       calendar_repeat,
  // status link
  input  wire logic             tx_status_clk,
  input  wire logic [1:0]       tx_status_lines,
  // data link
  output logic [15:0]           tx_data_bus,
  output logic                  tx_ctl,
  // user write side
  input  wire logic             fifo_clear_low,
  input  wire logic             wr_valid,
  output logic                  wr_ready,
  input  wire logic [15:0]      wr_data,
  input  wire logic [7:0]       wr_chan,
  input  wire logic             wr_sop,
  input  wire logic             wr_eop,
  input  wire logic             fifo_byte_modulo,
  // user status side
  output logic [1:0]            user_status_out,
  output logic [11:0]           user_status_slot,
  output logic                  user_status_valid,
  // flags
  output logic                  out_of_frame_flag,
  output logic                  parity_error_flag,
  output logic                  frame_word_error_flag,
  output logic                  frame_word_error_alias,
  output logic                  pattern_error_flag
);
  import ssse_pkg::*;

  ssse_state_t       state_reg;
  ssse_state_t       state_next;
  ssse_phase_t       phase_reg;
  ssse_tx_t          tx_st_reg;
  logic              st_stb;
  logic [1:0]        st_word;
  logic [11:0]       seq_len;
  logic [11:0]       slot_reg;
  logic [1:0]        acc_reg;
  logic              prev11_reg;
  logic [CNT_W-1:0]  match_reg;
  logic [CNT_W-1:0]  err_reg;
  logic [2:0]        run11_reg;
  logic              is11;
  logic              dip_ev;
  logic              dip_ok;
  logic              frame_bad;
  logic              entry_ev;
  logic              go_sync;
  logic              go_hunt;
  logic              wr_take;
  logic              chan_change;
  logic              mid_credit;
  logic              abort_flag;
  logic              pat_err;
  logic [15:0]       data_fixed;
  logic [SSSE_FE_W-1:0] f_in;
  logic              f_valid;
  logic              f_ready;
  logic [SSSE_FE_W-1:0] f_out;
  logic              pkt_open_reg;
  logic [7:0]        last_chan_reg;
  logic [2:0]        credit_pos_reg;
  logic [2:0]        burst_cnt_reg;
  logic [1:0]        eops_reg;
  logic [4:0]        train_reg;

  // ----------------------------------------
  // status sampling
  // ----------------------------------------
  ssse_sampler u_sampler (
    .clk       (clk),
    .resetn    (resetn),
    .link_clk  (tx_status_clk),
    .link_data (tx_status_lines),
    .word_stb  (st_stb),
    .word      (st_word)
  );

  assign seq_len   = {4'h0, calendar_length} * ({8'h00, calendar_repeat} + 12'h001);
  assign is11      = st_word == SSSE_STAT_FRAME;
  assign dip_ev    = st_stb & (phase_reg == PH_DIP);
  assign dip_ok    = st_word == ~acc_reg;
  assign frame_bad = st_stb & (phase_reg == PH_FRAME) & ~is11;
  assign entry_ev  = st_stb & (phase_reg == PH_ENTRY);

  // ----------------------------------------
  // status deframer
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn || !source_enable || go_hunt) begin
      phase_reg  <= PH_SEARCH;
      slot_reg   <= 12'h000;
      acc_reg    <= SSSE_DIP2_SEED;
      prev11_reg <= 1'b0;
    end else if (st_stb) begin
      prev11_reg <= is11;
      case (phase_reg)
        PH_SEARCH: begin
          if (prev11_reg && !is11) begin
            acc_reg   <= ssse_dip2_step(SSSE_DIP2_SEED, st_word);
            slot_reg  <= 12'h001;
            phase_reg <= (seq_len == 12'h001) ? PH_DIP : PH_ENTRY;
          end
        end
        PH_ENTRY: begin
          acc_reg  <= ssse_dip2_step(acc_reg, st_word);
          slot_reg <= slot_reg + 12'h001;
          if (slot_reg + 12'h001 >= seq_len) begin
            phase_reg <= PH_DIP;
          end
        end
        PH_DIP: begin
          phase_reg <= PH_FRAME;
        end
        PH_FRAME: begin
          if (state_reg == SSSE_SYNC) begin
            slot_reg  <= 12'h000;
            acc_reg   <= SSSE_DIP2_SEED;
            phase_reg <= PH_ENTRY;
          end else begin
            // out of frame, wait for next transition
            phase_reg <= PH_SEARCH;
          end
        end
        default: begin
          phase_reg <= PH_SEARCH;
        end
      endcase
    end
  end

  // ----------------------------------------
  // sync state machine
  // ----------------------------------------
  // acquisition gated by enable
  assign go_sync = (state_reg == SSSE_HUNT) & source_enable & dip_ev & dip_ok
                   & (match_reg + 1'b1 >= sync_match_count);
  assign go_hunt = (state_reg == SSSE_SYNC)
                   & (~source_enable
                      | (dip_ev & ~dip_ok & (err_reg + 1'b1 >= loss_error_count))
                      | (st_stb & is11 & (run11_reg == 3'(SSSE_FRAME_LOSS_RUN - 1))));

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SSSE_RESET: state_next = SSSE_HUNT;
      SSSE_HUNT:  state_next = go_sync ? SSSE_SYNC : SSSE_HUNT;
      SSSE_SYNC:  state_next = go_hunt ? SSSE_HUNT : SSSE_SYNC;
      default:    state_next = SSSE_RESET;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_reg         <= SSSE_RESET;
      out_of_frame_flag <= 1'b1;
    end else begin
      state_reg         <= state_next;
      out_of_frame_flag <= state_next != SSSE_SYNC;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn || !source_enable || state_reg == SSSE_RESET || go_sync || go_hunt) begin
      match_reg <= '0;
      err_reg   <= '0;
    end else if (dip_ev) begin
      match_reg <= dip_ok ? match_reg + 1'b1 : '0;
      err_reg   <= dip_ok ? '0 : err_reg + 1'b1;
    end else if (frame_bad && state_reg == SSSE_HUNT) begin
      match_reg <= '0;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn || state_reg != SSSE_SYNC) begin
      run11_reg <= 3'h0;
    end else if (st_stb) begin
      run11_reg <= is11 ? run11_reg + 3'h1 : 3'h0;
    end
  end

  // ----------------------------------------
  // status flags
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      parity_error_flag      <= 1'b0;
      frame_word_error_flag  <= 1'b0;
      frame_word_error_alias <= 1'b0;
    end else begin
      parity_error_flag      <= dip_ev & ~dip_ok;
      frame_word_error_flag  <= frame_bad;
      frame_word_error_alias <= frame_bad;
    end
  end

  // ----------------------------------------
  // user status
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      user_status_out   <= SSSE_STAT_SATISFIED;
      user_status_slot  <= 12'h000;
      user_status_valid <= 1'b0;
    end else if (state_reg == SSSE_SYNC) begin
      // forward received status
      // no pulse for the word on which frame is lost
      user_status_valid <= entry_ev & ~go_hunt;
      if (entry_ev) begin
        user_status_out  <= st_word;
        user_status_slot <= slot_reg;
      end
    end else begin
      user_status_out   <= SSSE_STAT_SATISFIED;
      user_status_valid <= 1'b0;
    end
  end

  // ----------------------------------------
  // write side checks
  // ----------------------------------------
  assign wr_take     = wr_valid & wr_ready;
  assign chan_change = wr_chan != last_chan_reg;
  assign mid_credit  = pkt_open_reg & (credit_pos_reg != 3'h0);
  // abort only on sop or new channel
  assign abort_flag  = mid_credit & (wr_sop | chan_change);
  assign pat_err     = (mid_credit & chan_change)
                       | (fifo_byte_modulo & ~wr_eop)
                       | (fifo_byte_modulo & wr_eop & (wr_data[7:0] != 8'h00));
  assign data_fixed  = (wr_eop & fifo_byte_modulo) ? {wr_data[15:8], 8'h00} : wr_data;
  assign f_in        = {abort_flag, wr_sop, wr_eop, fifo_byte_modulo & wr_eop,
                        wr_chan, data_fixed};

  always_ff @(posedge clk) begin
    if (!resetn || !fifo_clear_low) begin
      pkt_open_reg       <= 1'b0;
      last_chan_reg      <= 8'h00;
      credit_pos_reg     <= 3'h0;
      pattern_error_flag <= 1'b0;
    end else begin
      pattern_error_flag <= wr_take & pat_err;
      if (wr_take) begin
        pkt_open_reg  <= ~wr_eop;
        last_chan_reg <= wr_chan;
        if (wr_eop) begin
          credit_pos_reg <= 3'h0;
        end else if (wr_sop || chan_change) begin
          credit_pos_reg <= 3'h1;
        end else begin
          credit_pos_reg <= credit_pos_reg + 3'h1;
        end
      end
    end
  end

  // fifo clear leaves the sync state alone
  ssse_fifo #(
    .W     (SSSE_FE_W),
    .DEPTH (SSSE_FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .resetn    (resetn),
    .clear_low (fifo_clear_low),
    .in_valid  (wr_valid),
    .in_ready  (wr_ready),
    .in_data   (f_in),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_out)
  );

  // ----------------------------------------
  // transmit path
  // ----------------------------------------
  // drain only inside a burst; an empty fifo ends the burst early with an idle word
  assign f_ready = tx_st_reg == TX_BURST;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      tx_st_reg     <= TX_GAP;
      tx_data_bus   <= ssse_ctl_word(1'b0, SSSE_EOPS_NONE, 1'b0, 8'h00);
      tx_ctl        <= 1'b1;
      burst_cnt_reg <= 3'h0;
      eops_reg      <= SSSE_EOPS_NONE;
      train_reg     <= 5'h00;
    end else begin
      case (tx_st_reg)
        TX_BURST: begin
          train_reg <= 5'h00;
          if (f_valid) begin
            tx_data_bus   <= f_out[15:0];
            tx_ctl        <= 1'b0;
            burst_cnt_reg <= burst_cnt_reg + 3'h1;
            if (f_out[SSSE_FE_EOP_BIT]) begin
              eops_reg  <= f_out[SSSE_FE_MOD_BIT] ? SSSE_EOPS_ONE : SSSE_EOPS_TWO;
              tx_st_reg <= TX_GAP;
            end else if (burst_cnt_reg == 3'(SSSE_CREDIT_WORDS - 1)) begin
              tx_st_reg <= TX_GAP;
            end
          end else begin
            // paused mid-burst: close it with an idle word
            tx_data_bus <= ssse_ctl_word(1'b0, SSSE_EOPS_NONE, 1'b0, 8'h00);
            tx_ctl      <= 1'b1;
            tx_st_reg   <= TX_GAP;
          end
        end
        TX_GAP: begin
          tx_ctl <= 1'b1;
          if (state_reg == SSSE_SYNC && f_valid) begin
            // abort carried in the opening control word
            tx_data_bus   <= ssse_ctl_word(1'b1,
                               f_out[SSSE_FE_ABORT_BIT] ? SSSE_EOPS_ABORT : eops_reg,
                               f_out[SSSE_FE_SOP_BIT],
                               f_out[SSSE_FE_CHAN_LSB +: 8]);
            eops_reg      <= SSSE_EOPS_NONE;
            burst_cnt_reg <= 3'h0;
            tx_st_reg     <= TX_BURST;
            train_reg     <= 5'h00;
          end else if (state_reg == SSSE_SYNC || eops_reg != SSSE_EOPS_NONE) begin
            // pending end of packet goes out before training starts
            tx_data_bus <= ssse_ctl_word(1'b0, eops_reg, 1'b0, 8'h00);
            eops_reg    <= SSSE_EOPS_NONE;
            train_reg   <= 5'h00;
          end else begin
            if (train_reg == 5'h00) begin
              tx_data_bus <= ssse_ctl_word(1'b0, SSSE_EOPS_NONE, 1'b0, 8'h00);
            end else if (train_reg <= 5'(SSSE_TRAIN_REPS)) begin
              tx_data_bus <= SSSE_TRAIN_CTL;
            end else begin
              tx_data_bus <= SSSE_TRAIN_DATA;
              tx_ctl      <= 1'b0;
            end
            train_reg <= (train_reg == 5'(SSSE_TRAIN_LEN - 1)) ? 5'h00 : train_reg + 5'h01;
          end
        end
        default: begin
          tx_st_reg <= TX_GAP;
        end
      endcase
    end
  end
endmodule

// *** sim/ssse_sink_model.sv ***
`timescale 1ns/10ps
module ssse_sink_model (
  // bench controls
  input wire logic       run, bad_par, all_frame,
  input wire logic [7:0] n_entries,
  // status link
  output logic           link_clk,
  output logic [1:0]     link_lines
);
  logic [1:0] acc;
  int         idx;
  initial begin
    link_clk = 1'b0;
    link_lines = 2'h3;
    acc = 2'h0;
    idx = 0;
    forever begin
      #160;
      // clock stands still when idle, lines wander so a stale word never looks valid
      if (!run)
        link_lines = ~link_lines;
      else if (link_clk)
        link_clk = 1'b0;
      else begin
        link_clk = 1'b1;
        // frame, entries, parity
        // a bad-parity run also spoils the frame word
        if (all_frame || (idx == 0 && !bad_par))
          link_lines = 2'h3;
        else if (idx <= n_entries)
          link_lines = {1'b0, idx[0]};
        else
          link_lines = bad_par ? acc : ~acc;
        if (idx > 0 && idx <= n_entries)
          acc = {acc[0] ^ link_lines[1], acc[1] ^ link_lines[0]};
        idx = (idx > n_entries) ? 0 : idx + 1;
        if (idx == 0)
          acc = 2'h0;
      end
    end
  end
endmodule

// *** sim/ssse_monitor.sv ***
`timescale 1ns/10ps
module ssse_monitor #(
  parameter int CNT_W = 4
) (
  // clock, reset and controls
  input wire logic        clk, resetn, source_enable, wr_valid, wr_ready,
  // watched outputs
  input wire logic [15:0] tx_data_bus,
  input wire logic [1:0]  user_status_out,
  input wire logic        tx_ctl, user_status_valid, out_of_frame_flag, parity_error_flag,
  input wire logic        frame_word_error_flag, frame_word_error_alias, pattern_error_flag
);
  default clocking @(posedge clk);
  endclocking
  // a burst under way may finish after frame loss, so allow it before training
  sequence s_long_oof;
    out_of_frame_flag [*8] ##1 out_of_frame_flag [*6];
  endsequence
  sequence s_enable_low;
    !source_enable [*4];
  endsequence
  reset_idle_a: assert property (
    !resetn |=> out_of_frame_flag && tx_ctl && tx_data_bus == 16'h000f && user_status_out == 2'h2)
    else $error("outputs not idle in reset");
  hunt_status_a: assert property (disable iff (!resetn)
    out_of_frame_flag && $past(out_of_frame_flag) |-> user_status_out == 2'h2
    && !user_status_valid) else $error("status not satisfied in hunt");
  enable_only_a: assert property (disable iff (!resetn)
    s_enable_low |-> out_of_frame_flag) else $error("in frame without enable");
  training_only_a: assert property (disable iff (!resetn)
    s_long_oof |-> (tx_ctl ? tx_data_bus == 16'h000f || tx_data_bus == 16'h0fff
    : tx_data_bus == 16'hf000)) else $error("no training while out of frame");
  valid_sync_a: assert property (disable iff (!resetn)
    user_status_valid |-> !out_of_frame_flag) else $error("status valid out of frame");
  frame_alias_a: assert property (disable iff (!resetn)
    frame_word_error_flag == frame_word_error_alias) else $error("frame flags differ");
  parity_apart_a: assert property (disable iff (!resetn)
    parity_error_flag |-> !frame_word_error_flag ##1 !parity_error_flag)
    else $error("parity flag not a pulse");
  pattern_cause_a: assert property (disable iff (!resetn)
    pattern_error_flag |-> $past(wr_valid) && $past(wr_ready)
    || $past(wr_valid, 2) && $past(wr_ready, 2)) else $error("pattern flag without write");
endmodule
bind ssse_top ssse_monitor #(.CNT_W(CNT_W)) ssse_monitor_inst (.clk(clk), .resetn(resetn),
  .source_enable(source_enable), .wr_valid(wr_valid), .wr_ready(wr_ready),
  .tx_data_bus(tx_data_bus), .user_status_out(user_status_out), .tx_ctl(tx_ctl),
  .user_status_valid(user_status_valid), .out_of_frame_flag(out_of_frame_flag),
  .parity_error_flag(parity_error_flag), .frame_word_error_flag(frame_word_error_flag),
  .frame_word_error_alias(frame_word_error_alias), .pattern_error_flag(pattern_error_flag));

// *** sim/ssse_top_tb.sv ***
`timescale 1ns/10ps
module ssse_top_tb;
  logic        clk, resetn, source_enable, fifo_clear_low, wr_valid, wr_ready, wr_sop, wr_eop;
  logic        fifo_byte_modulo, tx_ctl, user_status_valid, oof, perr, pat, stat_clk, ferr;
  logic        run, bad_par, all_frame;
  logic [15:0] wr_data, tx_data_bus;
  logic [11:0] slot;
  logic [7:0]  wr_chan;
  logic [6:0]  evs;
  logic [4:0]  sticky;
  logic [3:0]  need_good, need_bad;
  logic [1:0]  user_status_out, stat_lines;
  int          miscompares = 0, compares = 0, n, taken;
  assign evs = {user_status_valid, sticky, oof};
  ssse_top #(.CNT_W(4)) ssse_top_inst (.clk(clk), .resetn(resetn),
    .source_enable(source_enable), .sync_match_count(need_good), .loss_error_count(need_bad),
    .calendar_length(8'h02), .calendar_repeat(4'h1), .tx_status_clk(stat_clk),
    .tx_status_lines(stat_lines), .tx_data_bus(tx_data_bus), .tx_ctl(tx_ctl),
    .fifo_clear_low(fifo_clear_low), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_data(wr_data), .wr_chan(wr_chan), .wr_sop(wr_sop), .wr_eop(wr_eop),
    .fifo_byte_modulo(fifo_byte_modulo), .user_status_out(user_status_out),
    .user_status_slot(slot), .user_status_valid(user_status_valid), .out_of_frame_flag(oof),
    .parity_error_flag(perr), .frame_word_error_flag(ferr), .frame_word_error_alias(),
    .pattern_error_flag(pat));
  ssse_sink_model ssse_sink_model_inst (.run(run), .bad_par(bad_par), .all_frame(all_frame),
    .n_entries(8'h04), .link_clk(stat_clk), .link_lines(stat_lines));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // seen-once marks: frame error, held data, parity error, zeroed pad, abort word
  always @(posedge clk)
    sticky <= !resetn ? 5'h00 : sticky | {ferr, !tx_ctl && tx_data_bus == 16'h1100, perr,
                        !tx_ctl && tx_data_bus == 16'h1200, tx_ctl && tx_data_bus[14:13] == 2'h1};
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic wait_until(input int k, input logic v, input int lim);
    n = 0;
    while (evs[k] !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
    check("awaited event", 16'(evs[k]), 16'(v));
    if (evs[k] !== v)
      results();
  endtask
  // sem is {sop, eop, modulo}; the flag may land one or two edges after the take
  task automatic wr(input logic [15:0] d, input logic [7:0] ch, input logic [2:0] sem,
                    input logic xp);
    logic seen;
    @(posedge clk);
    {wr_valid, wr_data, wr_chan, wr_sop, wr_eop, fifo_byte_modulo} <= {1'b1, d, ch, sem};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wr_ready !== 1'b1 && n < 40);
    wr_valid <= 1'b0;
    if (wr_ready !== 1'b1)
      results();
    #1 seen = pat;
    @(posedge clk);
    #1 seen = seen | pat;
    check("pattern flag", 16'(seen), 16'(xp));
  endtask
  initial begin
    {resetn, source_enable, wr_valid, wr_sop, wr_eop, fifo_byte_modulo} = 6'h00;
    {fifo_clear_low, run, bad_par, all_frame, need_good, need_bad} = 12'h822;
    {wr_data, wr_chan} = 24'h000000;
    repeat (16) @(posedge clk);
    check("reset word", tx_data_bus, 16'h000f);
    check("reset flags", {tx_ctl, oof, user_status_out}, 16'h000e);
    resetn <= 1'b1;
    run <= 1'b1;
    taken = 0;
    wr_valid <= 1'b1;
    wr_chan <= 8'h01;
    for (int i = 0; i < 40; i++) begin
      wr_sop <= (taken == 0);
      wr_data <= 16'h1100 + 16'(taken);
      @(posedge clk);
      if (wr_ready === 1'b1)
        taken++;
    end
    wr_valid <= 1'b0;
    check("fill count", 16'(taken), 16'h0011);
    check("hunt status", {oof, user_status_out}, 16'h0006);
    $display("test hunt and fill done");
    source_enable <= 1'b1;
    wait_until(0, 1'b0, 1000);
    wait_until(4, 1'b1, 300);
    wait_until(6, 1'b1, 200);
    check("entry status", user_status_out, slot[0] ? 16'h0000 : 16'h0001);
    wr(16'h2000, 8'h01, 3'h4, 1'b0);
    wr(16'h2100, 8'h03, 3'h0, 1'b1);
    wr(16'h2200, 8'h03, 3'h1, 1'b1);
    wr(16'h12ab, 8'h03, 3'h3, 1'b1);
    wr(16'h3400, 8'h04, 3'h7, 1'b0);
    wait_until(2, 1'b1, 300);
    wait_until(1, 1'b1, 1);
    fifo_clear_low <= 1'b0;
    @(posedge clk);
    fifo_clear_low <= 1'b1;
    repeat (3) @(posedge clk);
    check("frame kept", 16'(oof), 16'h0000);
    $display("test sync traffic done");
    need_bad <= 4'h3;
    bad_par <= 1'b1;
    wait_until(0, 1'b1, 400);
    wait_until(3, 1'b1, 1);
    wait_until(5, 1'b1, 1);
    bad_par <= 1'b0;
    wait_until(0, 1'b0, 1000);
    all_frame <= 1'b1;
    wait_until(0, 1'b1, 100);
    all_frame <= 1'b0;
    wait_until(0, 1'b0, 1000);
    source_enable <= 1'b0;
    wait_until(0, 1'b1, 4);
    $display("test frame loss done");
    results();
  end
endmodule
